/* File: ild_pkg.sv */
// constants for the input level detector
package ild_pkg;

  // ----------------------------------------------------------------
  // register offsets (address port holds the printed offsets)
  // ----------------------------------------------------------------
  localparam logic [15:0] ILD_OFS_CFG    = 16'hf805; // detector configuration
  localparam logic [15:0] ILD_OFS_START  = 16'hf806; // start strobe (write), level read
  localparam logic [15:0] ILD_OFS_TEST   = 16'hf807; // processor test input word
  localparam logic [15:0] ILD_OFS_TSTRB  = 16'hf808; // test input strobe location
  localparam logic [15:0] ILD_OFS_INCTL  = 16'hf810; // input control
  localparam logic [15:0] ILD_OFS_STAT   = 16'hf811; // sticky status
  localparam logic [15:0] ILD_OFS_MASK   = 16'hf812; // interrupt mask

  // ----------------------------------------------------------------
  // configuration fields
  // ----------------------------------------------------------------
  localparam int          ILD_CFG_W      = 22;       // stored bits 21:0
  localparam int          ILD_CFG_RECT   = 21;       // rectify
  localparam int          ILD_CFG_FREE   = 20;       // free run
  localparam int          ILD_CFG_LEAK   = 18;       // leak factor lsb, 2 bits
  localparam int          ILD_CFG_MODE   = 16;       // detector mode lsb, 2 bits
  localparam int          ILD_CFG_IVL    = 0;        // interval lsb, 16 bits
  localparam logic [21:0] ILD_CFG_RST    = 22'h000000;

  // ----------------------------------------------------------------
  // input control fields
  // ----------------------------------------------------------------
  localparam int          ILD_IC_TSEL    = 0;        // detector takes test word
  localparam int          ILD_IC_INTERP  = 3;        // interpolated mode
  localparam int          ILD_IC_DMX     = 4;        // demux delay lsb, 3 bits
  localparam int          ILD_IC_TLVL    = 11;       // test strobe level
  localparam int          ILD_IC_TSRC    = 12;       // test strobe from write pulse
  localparam logic [12:0] ILD_IC_RST     = 13'h0000;

  // ----------------------------------------------------------------
  // status and detector constants
  // ----------------------------------------------------------------
  localparam int          ILD_ST_DONE    = 1;        // interval complete
  localparam logic [1:0]  ILD_ST_RST     = 2'h0;
  localparam int          ILD_FRAC       = 16;       // fraction bits of accumulator
  localparam int          ILD_DMX_MAX    = 7;        // deepest demux delay

  // detector modes
  typedef enum logic [1:0] {
    ILD_LEAKY = 2'h0,
    ILD_PEAK  = 2'h1,
    ILD_INTEG = 2'h2,
    ILD_RSVD  = 2'h3
  } ild_mode_t;

endpackage : ild_pkg

/* File: ild_smp_if.sv */
// sample path between the detector core and its strobe delay line
`timescale 1ns/1ns
interface ild_smp_if;
  logic        strobe_raw; // undelayed sample strobe
  logic [15:0] sample_raw; // undelayed sample
  logic [2:0]  dmx;        // delay in clocks
  logic        strobe_dly; // strobe after delay
  logic [15:0] sample_cap; // sample taken at the delayed strobe clock

  modport core (output strobe_raw, output sample_raw, output dmx, input strobe_dly, input sample_cap);
  modport dly  (input strobe_raw, input sample_raw, input dmx, output strobe_dly, output sample_cap);
endinterface : ild_smp_if

/* File: ild_dly.sv */
// demultiplex delay line for the sample strobe
`timescale 1ns/1ns
module ild_dly
  import ild_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic nrst,
  ild_smp_if.dly    smp
);

  // ----------------------------------------------------------------
  // delay taps
  // ----------------------------------------------------------------
  logic [ILD_DMX_MAX-1:0] tap_r;      // strobe history, tap 0 is one clock old

  // shift strobe history each clock; the sample itself needs no history
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tap_r <= '0;
    end else begin
      tap_r <= {tap_r[ILD_DMX_MAX-2:0], smp.strobe_raw};
    end
  end

  // pick the tap; sample is the one on the bus at the delayed clock
  always_comb begin
    if (smp.dmx == 3'h0) begin // zero delay
      smp.strobe_dly = smp.strobe_raw;
    end else begin // one to seven clocks
      smp.strobe_dly = tap_r[smp.dmx - 3'h1];
    end
    smp.sample_cap = smp.sample_raw;
  end

endmodule : ild_dly

/* File: ild_rect.sv */
// optional rectifier of a formatted sample
`timescale 1ns/1ns
module ild_rect (
  input  wire logic        en,   // rectify enable
  input  wire logic [15:0] din,  // two's complement sample
  output logic      [15:0] dout  // rectified sample
);

  // ones complement negative values only
  always_comb begin
    if (en && din[15]) begin // negative sample
      dout = ~din;
    end else begin // unmodified
      dout = din;
    end
  end

endmodule : ild_rect

/* File: ild_top.sv */
// input level detector: register file, interval counter and accumulator
//
// Overview of operation
// - Demux field delays capture zero to seven clocks
// - Gated mode updates only on enable strobe
// - Interpolated mode updates always, zero when strobed
// - Rectify ones-complements negative samples
// - Free run ignores interval; else stop
// - Leak code selects gain 1, 2^-8, -12, -16
// - Leaky: y = A*x + (1-A)*y
// - Mode 01 peak, 10 integrate, 11 holds
// - Interval field is sample count minus two
// - Start write clears accumulator, restarts counter
// - Interval finish sets status bit one
// - Processor test word selectable as input
// - Test strobe from bit 11 or write pulse
// - Strobe-location write makes one test strobe
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ns
module ild_top
  import ild_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic [15:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic [15:0] sample_in,
  input  wire logic        input_sample_strobe,
  output logic             irq
);

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [ILD_CFG_W-1:0] cfg_r;       // detector configuration
  logic [12:0]          inctl_r;     // input control
  logic [15:0]          test_r;      // processor test word
  logic [1:0]           stat_r;      // sticky status
  logic [1:0]           mask_r;      // interrupt mask
  logic [31:0]          rdata_r;     // read data, one cycle after strobe
  logic                 irq_r;       // interrupt level
  logic                 tpulse_r;    // write pulse at strobe location

  // decoded write strobes
  logic                 wr_cfg;
  logic                 wr_start;
  logic                 wr_test;
  logic                 wr_tstrb;
  logic                 wr_inctl;
  logic                 wr_stat;
  logic                 wr_mask;

  assign wr_cfg   = reg_wr && (reg_addr == ILD_OFS_CFG);
  assign wr_start = reg_wr && (reg_addr == ILD_OFS_START);
  assign wr_test  = reg_wr && (reg_addr == ILD_OFS_TEST);
  assign wr_tstrb = reg_wr && (reg_addr == ILD_OFS_TSTRB);
  assign wr_inctl = reg_wr && (reg_addr == ILD_OFS_INCTL);
  assign wr_stat  = reg_wr && (reg_addr == ILD_OFS_STAT);
  assign wr_mask  = reg_wr && (reg_addr == ILD_OFS_MASK);

  // configuration fields
  logic                 rect_en;
  logic                 free_run;
  logic [1:0]           leak;
  ild_mode_t            mode;
  logic [15:0]          ivl;

  assign rect_en  = cfg_r[ILD_CFG_RECT];
  assign free_run = cfg_r[ILD_CFG_FREE];
  assign leak     = cfg_r[ILD_CFG_LEAK +: 2];
  assign mode     = ild_mode_t'(cfg_r[ILD_CFG_MODE +: 2]);
  assign ivl      = cfg_r[ILD_CFG_IVL +: 16];

  // configuration, input control and test word
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_r   <= ILD_CFG_RST;
      inctl_r <= ILD_IC_RST;
      test_r  <= 16'h0000;
      mask_r  <= ILD_ST_RST;
    end else begin
      if (wr_cfg)   cfg_r   <= reg_wdata[ILD_CFG_W-1:0];
      if (wr_inctl) inctl_r <= reg_wdata[12:0];
      if (wr_test)  test_r  <= reg_wdata[15:0];
      if (wr_mask)  mask_r  <= reg_wdata[1:0];
    end
  end

  // one clock test strobe per write to the strobe location
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tpulse_r <= 1'b0;
    end else begin
      tpulse_r <= wr_tstrb;
    end
  end

  // ----------------------------------------------------------------
  // sample source and strobe delay
  // ----------------------------------------------------------------
  ild_smp_if smp ();

  logic                 test_stb;    // strobe of the test word

  // test strobe from level bit or from write pulse
  always_comb begin
    if (inctl_r[ILD_IC_TSRC]) begin // write pulse source
      test_stb = tpulse_r;
    end else begin // level bit source
      test_stb = inctl_r[ILD_IC_TLVL];
    end
  end

  // pin or test word feeds the delay line
  assign smp.strobe_raw = inctl_r[ILD_IC_TSEL] ? test_stb : input_sample_strobe;
  assign smp.sample_raw = inctl_r[ILD_IC_TSEL] ? test_r : sample_in;
  assign smp.dmx        = inctl_r[ILD_IC_DMX +: 3];

  ild_dly u_dly (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .smp     (smp)
  );

  logic [15:0]          rect_x;      // rectified sample
  logic [15:0]          x_in;        // detector input
  logic                 interp;      // interpolated mode
  logic                 upd;         // detector update this clock

  ild_rect u_rect (
    .en   (rect_en),
    .din  (smp.sample_cap),
    .dout (rect_x)
  );

  assign interp = inctl_r[ILD_IC_INTERP];

  // zero the input on strobe in interpolated mode
  assign x_in = (interp && smp.strobe_dly) ? 16'h0000 : rect_x;

  // ----------------------------------------------------------------
  // interval counter
  // ----------------------------------------------------------------
  logic [16:0]          cnt_r;       // samples left minus one
  logic                 run_r;       // interval measurement active
  logic                 active;      // accumulator may change
  logic                 done_evt;    // last sample of the interval

  // a start in the same clock as the last sample wins, so no stale done
  // free run bypasses the interval counter
  assign active   = free_run || run_r;
  assign upd      = active && (interp || smp.strobe_dly);
  assign done_evt = !wr_start && run_r && upd && (cnt_r == 17'h00000);

  // load field plus one, count updates down to zero
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 17'h00000;
      run_r <= 1'b0;
    end else if (wr_start) begin // restart
      cnt_r <= {1'b0, ivl} + 17'h00001; // field + 2 samples
      run_r <= 1'b1;
    end else if (run_r && upd) begin
      if (cnt_r == 17'h00000) begin // interval over
        run_r <= 1'b0;
      end else begin
        cnt_r <= cnt_r - 17'h00001;
      end
    end
  end

  // ----------------------------------------------------------------
  // accumulator
  // ----------------------------------------------------------------
  logic signed [47:0]   acc_r;       // leaky and peak scaled by 2^16
  logic signed [47:0]   x_ext;       // input, scaled
  logic signed [47:0]   x_int;       // input, unscaled
  logic signed [47:0]   diff;        // input minus output
  logic signed [47:0]   leak_step;   // A times difference
  logic signed [47:0]   acc_nxt;

  assign x_ext = {{16{x_in[15]}}, x_in, 16'h0000};
  assign x_int = {{32{x_in[15]}}, x_in};
  assign diff  = x_ext - acc_r;

  // leak gain as an arithmetic shift
  always_comb begin
    unique case (leak)
      2'h0: leak_step = diff;
      2'h1: leak_step = diff >>> 8;
      2'h2: leak_step = diff >>> 12;
      2'h3: leak_step = diff >>> 16;
    endcase
  end

  // next value per detector mode
  always_comb begin
    unique case (mode)
      ILD_LEAKY: acc_nxt = acc_r + leak_step;
      ILD_PEAK:  acc_nxt = (x_ext > acc_r) ? x_ext : acc_r;
      ILD_INTEG: acc_nxt = acc_r + x_int;
      ILD_RSVD:  acc_nxt = acc_r;                              // hold
    endcase
  end

  // clear on start, else update when enabled
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      acc_r <= 48'sh0;
    end else if (wr_start) begin // clear
      acc_r <= 48'sh0;
    end else if (upd) begin
      acc_r <= acc_nxt;
    end
  end

  // integrator keeps the raw low word, long runs of large samples wrap
  // level as read: scaled modes drop the fraction
  logic [31:0]          level;
  assign level = (mode == ILD_INTEG) ? acc_r[31:0] : acc_r[ILD_FRAC +: 32];

  // ----------------------------------------------------------------
  // status and interrupt
  // ----------------------------------------------------------------
  // sticky done, write one to clear, set wins
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      stat_r <= ILD_ST_RST;
    end else begin
      if (wr_stat) stat_r <= stat_r & ~reg_wdata[1:0];
      if (done_evt) stat_r[ILD_ST_DONE] <= 1'b1;
    end
  end

  // registered so the pin never glitches on a status write
  // level interrupt from unmasked status
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(stat_r & mask_r);
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  // read data valid one cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ILD_OFS_CFG:   rdata_r <= {10'h000, cfg_r};
        ILD_OFS_START: rdata_r <= level;
        ILD_OFS_TEST:  rdata_r <= {16'h0000, test_r};
        ILD_OFS_INCTL: rdata_r <= {19'h00000, inctl_r};
        ILD_OFS_STAT:  rdata_r <= {30'h0, stat_r};
        ILD_OFS_MASK:  rdata_r <= {30'h0, mask_r};
        default:       rdata_r <= 32'h0000_0000; // unmapped
      endcase
    end else begin
      rdata_r <= 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_r;
  assign irq       = irq_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // delay line and input path
  dly_zero_a: assert property (smp.dmx == 3'h0
    |-> smp.strobe_dly == smp.strobe_raw) else $error("zero delay strobe wrong");
  dly_three_a: assert property (smp.dmx == 3'h3 && $stable(smp.dmx) && $past(smp.strobe_raw, 3)
    |-> smp.strobe_dly) else $error("delayed strobe missing");
  interp_zero_a: assert property (interp && smp.strobe_dly
    |-> x_in == 16'h0000) else $error("interpolated input not zero");
  rect_neg_a: assert property (rect_en && smp.sample_cap[15] && !(interp && smp.strobe_dly)
    |-> x_in == ~smp.sample_cap) else $error("rectify wrong");
  rect_pass_a: assert property (!rect_en && !(interp && smp.strobe_dly)
    |-> x_in == smp.sample_cap) else $error("unrectified input changed");
  test_word_a: assert property (inctl_r[ILD_IC_TSEL]
    |-> smp.sample_raw == test_r) else $error("test word not selected");
  level_src_a: assert property (inctl_r[ILD_IC_TSEL] && !inctl_r[ILD_IC_TSRC]
    |-> smp.strobe_raw == inctl_r[ILD_IC_TLVL]) else $error("level test strobe wrong");
  test_pulse_a: assert property (wr_tstrb && inctl_r[ILD_IC_TSEL] && inctl_r[ILD_IC_TSRC] && !wr_inctl
    |=> smp.strobe_raw ##1 !smp.strobe_raw || $past(wr_tstrb)) else $error("test strobe not one clock");

  // update gating
  gated_take_a: assert property (!interp && smp.strobe_dly && active
    |-> upd) else $error("gated strobe missed");
  gated_hold_a: assert property (!interp && !smp.strobe_dly && !wr_start
    |=> $stable(acc_r)) else $error("gated update off strobe");
  free_upd_a: assert property (free_run && (interp || smp.strobe_dly)
    |-> upd) else $error("free run update missed");
  stop_hold_a: assert property (!free_run && !run_r && !wr_start
    |=> $stable(acc_r)) else $error("accumulator moved after stop");

  // accumulator modes
  leak_one_a: assert property (mode == ILD_LEAKY && leak == 2'h0 && upd && !wr_start
    |=> acc_r == $past(x_ext)) else $error("gain one wrong");
  peak_keep_a: assert property (mode == ILD_PEAK && upd && !wr_start
    |=> acc_r >= $past(acc_r)) else $error("peak dropped");
  peak_take_a: assert property (mode == ILD_PEAK && upd && !wr_start && x_ext > acc_r
    |=> acc_r == $past(x_ext)) else $error("new peak not taken");
  integ_sum_a: assert property (mode == ILD_INTEG && upd && !wr_start
    |=> acc_r == $past(acc_r) + $past(x_int)) else $error("integrate wrong");
  rsvd_hold_a: assert property (mode == ILD_RSVD && !wr_start
    |=> $stable(acc_r)) else $error("reserved mode moved");

  // interval, status and interrupt
  start_load_a: assert property (wr_start
    |=> acc_r == 48'sh0 && run_r && cnt_r == {1'b0, $past(ivl)} + 17'h00001) else $error("start did not clear");
  cnt_step_a: assert property (run_r && upd && !wr_start && cnt_r != 17'h00000
    |=> run_r && cnt_r == $past(cnt_r) - 17'h00001) else $error("interval count wrong");
  done_flag_a: assert property (done_evt
    |=> stat_r[ILD_ST_DONE] && !run_r) else $error("done not flagged");
  stat_clear_a: assert property (wr_stat && reg_wdata[ILD_ST_DONE] && !done_evt
    |=> !stat_r[ILD_ST_DONE]) else $error("done not cleared");
  irq_set_a: assert property (|(stat_r & mask_r)
    |=> irq_r) else $error("interrupt not raised");
  irq_clr_a: assert property (!(|(stat_r & mask_r))
    |=> !irq_r) else $error("interrupt not dropped");

  // main scenarios reached
  done_c:   cover property (done_evt);
  peak_c:   cover property (mode == ILD_PEAK && upd && x_ext > acc_r);
  interp_c: cover property (interp && smp.strobe_dly && upd);
  irq_c:    cover property (!irq_r ##1 irq_r);
  test_c:   cover property (tpulse_r && inctl_r[ILD_IC_TSEL] && upd);

endmodule : ild_top

/* File: ild_src.sv */
// sample source model: one strobed multiplexed set of eight streams per request
`timescale 1ns/1ns
module ild_src (
  input  wire logic  ref_clk,            // device clock
  output logic [15:0] sample_in,         // multiplexed sample bus
  output logic        input_sample_strobe // set strobe
);
  logic [3:0]  slot;  // stream slot now driven, 8 = idle
  logic [15:0] base;  // value of slot 0
  logic [15:0] step;  // increment per slot
  int          n_req; // sets requested
  int          n_done; // sets started

  initial begin
    sample_in           = 16'h0000;
    input_sample_strobe = 1'b0;
    slot                = 4'h8;
    n_req               = 0;
    n_done              = 0;
  end

  // drive one set, else toggle the idle bus so no stale value lingers
  always @(posedge ref_clk) begin
    if (slot < 4'h8) begin
      sample_in           <= base + step * 16'(slot);
      input_sample_strobe <= (slot == 4'h0); // one clock, first stream
      slot                <= slot + 4'h1;
    end else begin
      sample_in           <= ~sample_in;
      input_sample_strobe <= 1'b0;
      if (n_req != n_done) begin
        slot   <= 4'h0;
        n_done <= n_done + 1;
      end
    end
  end

  // request a set and wait until it has passed the deepest delay
  task automatic send(input logic [15:0] b, input logic [15:0] s);
    #1;
    base  = b;
    step  = s;
    n_req = n_req + 1;
    repeat (13) @(posedge ref_clk);
  endtask : send
endmodule : ild_src

/* File: ild_bench.sv */
// self-checking bench for the input level detector
`timescale 1ns/1ns
module ild_bench
  import ild_pkg::*;
;
  logic        ref_clk;             // 250 MHz clock
  logic        nrst;                // async reset, low
  logic [15:0] reg_addr;            // register address
  logic [31:0] reg_wdata;           // write data
  logic        reg_wr;              // write strobe
  logic        reg_rd;              // read strobe
  logic [31:0] reg_rdata;           // read data
  logic [15:0] sample_in;           // source samples
  logic        input_sample_strobe; // source strobe
  logic        irq;                 // interrupt level
  int          n_fail;              // mismatches
  int          total_checks;        // comparisons

  ild_top i_ild_top (
    .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_in(sample_in),
    .input_sample_strobe(input_sample_strobe), .irq(irq));

  ild_src i_ild_src (
    .ref_clk(ref_clk), .sample_in(sample_in), .input_sample_strobe(input_sample_strobe));

  // clock, 4 ns period
  initial ref_clk = 1'b0;
  always #2 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------
  // bus and check helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one-cycle write, strobe dropped before the next call
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // one-cycle read, data taken in the following cycle
  task automatic rchk(input logic [15:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rchk

  // configure then start a measurement
  task automatic go(input logic [31:0] c);
    wr(ILD_OFS_CFG, c);
    wr(ILD_OFS_START, 32'h0000_0000);
  endtask : go

  task automatic give_verdict;
    if (n_fail == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  // bounded wait for the interrupt level
  task automatic wait_irq(input logic exp);
    int i;
    #1;
    for (i = 0; i < 8 && irq !== exp; i++) begin
      @(posedge ref_clk);
      #1;
    end
    total_checks++;
    if (irq !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, irq, exp);
      give_verdict();
    end
  endtask : wait_irq

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rchk(ILD_OFS_CFG, 32'h0000_0000);
    rchk(ILD_OFS_STAT, 32'h0000_0000);
    rchk(ILD_OFS_TSTRB, 32'h0000_0000);
    rchk(16'h1234, 32'h0000_0000);
    wr(ILD_OFS_CFG, 32'hffff_ffff);
    rchk(ILD_OFS_CFG, 32'h003f_ffff);
  endtask : t_regs

  // each delay picks its own stream slot, gain 1 shows the last input
  task automatic t_demux;
    int d;
    for (d = 0; d < 8; d++) begin
      wr(ILD_OFS_INCTL, 32'(d) << ILD_IC_DMX);
      go(32'h0010_0000);
      i_ild_src.send(16'h0100, 16'h0100);
      rchk(ILD_OFS_START, 32'(16'h0100 * (d + 1)));
    end
    wr(ILD_OFS_INCTL, 32'h0000_0000);
  endtask : t_demux

  task automatic t_leak;
    logic [31:0] expv [3];
    int          k;
    expv = '{32'h0000_0070, 32'h0000_0007, 32'h0000_0000};
    for (k = 1; k < 4; k++) begin
      go(32'h0010_0000 | (32'(k) << ILD_CFG_LEAK));
      i_ild_src.send(16'h7000, 16'h0000);
      rchk(ILD_OFS_START, expv[k-1]);
    end
  endtask : t_leak

  task automatic t_peak;
    go(32'h0011_0000);
    i_ild_src.send(16'h0300, 16'h0000);
    i_ild_src.send(16'h0100, 16'h0000);
    i_ild_src.send(16'hf000, 16'h0000);
    rchk(ILD_OFS_START, 32'h0000_0300);
    go(32'h0031_0000);
    i_ild_src.send(16'hf000, 16'h0000);
    i_ild_src.send(16'h0200, 16'h0000);
    rchk(ILD_OFS_START, 32'h0000_0fff);
  endtask : t_peak

  task automatic t_free;
    go(32'h0011_0000);
    i_ild_src.send(16'h0100, 16'h0000);
    i_ild_src.send(16'h0200, 16'h0000);
    i_ild_src.send(16'h0300, 16'h0000);
    rchk(ILD_OFS_START, 32'h0000_0300);
    wr(ILD_OFS_CFG, 32'h0001_0000); // hold for reading
    i_ild_src.send(16'h0500, 16'h0000);
    rchk(ILD_OFS_START, 32'h0000_0300);
  endtask : t_free

  // integrate over interval 3, fourth set must be dropped
  task automatic t_ivl;
    go(32'h0002_0001); // free run cleared
    wr(ILD_OFS_STAT, 32'h0000_0002);
    rchk(ILD_OFS_STAT, 32'h0000_0000);
    rchk(ILD_OFS_START, 32'h0000_0000);
    wr(ILD_OFS_MASK, 32'h0000_0002);
    wait_irq(1'b0);
    repeat (4) i_ild_src.send(16'h0003, 16'h0000);
    rchk(ILD_OFS_START, 32'h0000_0009);
    rchk(ILD_OFS_STAT, 32'h0000_0002);
    wait_irq(1'b1);
    wr(ILD_OFS_STAT, 32'h0000_0002);
    rchk(ILD_OFS_STAT, 32'h0000_0000);
    wait_irq(1'b0);
  endtask : t_ivl

  task automatic t_test;
    wr(ILD_OFS_MASK, 32'h0000_0000);
    wr(ILD_OFS_INCTL, 32'h0000_1001);
    wr(ILD_OFS_TEST, 32'h0000_0005);
    rchk(ILD_OFS_TEST, 32'h0000_0005);
    go(32'h0002_0001);
    repeat (2) wr(ILD_OFS_TSTRB, 32'h0000_0000);
    rchk(ILD_OFS_START, 32'h0000_000a);
    rchk(ILD_OFS_STAT, 32'h0000_0000);
    repeat (2) wr(ILD_OFS_TSTRB, 32'h0000_0000);
    rchk(ILD_OFS_START, 32'h0000_000f);
    rchk(ILD_OFS_STAT, 32'h0000_0002);
    wait_irq(1'b0); // masked
    wr(ILD_OFS_STAT, 32'h0000_0002);
    wr(ILD_OFS_INCTL, 32'h0000_0009);
    go(32'h0002_0002);
    repeat (8) @(posedge ref_clk);
    rchk(ILD_OFS_START, 32'h0000_0014);
    wr(ILD_OFS_INCTL, 32'h0000_0809);
    go(32'h0002_0002);
    repeat (8) @(posedge ref_clk);
    rchk(ILD_OFS_START, 32'h0000_0000);
  endtask : t_test

  // main sequence
  initial begin
    n_fail       = 0;
    total_checks = 0;
    nrst         = 1'b0;
    reg_addr     = 16'h0000;
    reg_wdata    = 32'h0000_0000;
    reg_wr       = 1'b0;
    reg_rd       = 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    t_regs();
    t_demux();
    t_leak();
    t_peak();
    t_free();
    t_ivl();
    t_test();
    give_verdict();
  end
endmodule : ild_bench
